/* File: rtl/pch_decode.sv */
// Splits a command word into its fields and selection masks.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_decode
   (
   input wire logic [15:0] word_i,
   input wire logic [31:0] monitor_units_i,
   output pch_pkg::pch_issue_s issue_o
   );
   import pch_pkg::*;
   pch_cmd_s f;
   logic known;
   always_comb
   begin
      f = word_i;
      issue_o.code = f.code;
      issue_o.unit_mask = '0;
      issue_o.chan_mask = '0;
      known = 1'b0;
      case (f.code)
         `PCH_OP_RUN, `PCH_OP_STOP, `PCH_OP_MANUAL, `PCH_OP_AUTO,
         `PCH_OP_TUNE40, `PCH_OP_TUNE100, `PCH_OP_TUNECAN,
         `PCH_OP_SWRESET: known = 1'b1;
         default: known = 1'b0;
      endcase
      if (f.all_units)
         issue_o.unit_mask = '1;
      else if (f.unit <= `PCH_MAX_UNIT)
         issue_o.unit_mask[f.unit[4:0]] = 1'b1;
      if (f.all_units && f.code == `PCH_OP_RUN)
         issue_o.unit_mask = issue_o.unit_mask & ~monitor_units_i;
      if (f.all_units && f.code == `PCH_OP_SWRESET)
         issue_o.unit_mask = issue_o.unit_mask & ~monitor_units_i;
      if (f.all_chans)
         issue_o.chan_mask = 4'hF;
      else
         issue_o.chan_mask[f.chan] = 1'b1;
      issue_o.valid = known && (issue_o.unit_mask != '0);
   end
endmodule // pch_decode
`default_nettype wire

/* File: rtl/pch_handshake.sv */
// One request/response handshake channel that forbids direct code changes.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_handshake
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [15:0] req_i,
   input wire logic done_i,
   output logic [15:0] active_o,
   output logic start_o,
   output logic [15:0] resp_o
   );
   logic [15:0] active_ff;
   logic [15:0] resp_ff;
   logic start_ff;
   logic legal;
   assign legal = (req_i <= `PCH_REQ_BMULTI);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_ff <= `PCH_REQ_STOP;
         start_ff <= 1'b0;
      end
      else
      begin
         start_ff <= 1'b0;
         if (active_ff == `PCH_REQ_STOP && resp_ff == `PCH_REQ_STOP &&
            req_i != `PCH_REQ_STOP && legal)
         begin
            active_ff <= req_i;
            start_ff <= 1'b1;
         end
         else if (req_i == `PCH_REQ_STOP && done_i)
            active_ff <= `PCH_REQ_STOP;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         resp_ff <= `PCH_REQ_STOP;
      else if (active_ff == `PCH_REQ_STOP && done_i)
         resp_ff <= `PCH_REQ_STOP;
      // Wait out the start cycle so that the echo follows the action.
      else if (active_ff != `PCH_REQ_STOP && done_i && !start_ff)
         resp_ff <= active_ff;
   end
   assign active_o = active_ff;
   assign start_o = start_ff;
   assign resp_o = resp_ff;
endmodule // pch_handshake
`default_nettype wire

/* File: rtl/pch_pkg.sv */
// Types shared by the command handshake block.
package pch_pkg;
   typedef struct packed {
      logic [5:0] code;
      logic [5:0] unit;
      logic all_units;
      logic [1:0] chan;
      logic all_chans;
   } pch_cmd_s;
   typedef struct packed {
      logic valid;
      logic [5:0] code;
      logic [31:0] unit_mask;
      logic [3:0] chan_mask;
   } pch_issue_s;
   typedef enum logic [1:0] {PCH_IDLE, PCH_BUSY, PCH_DONE} pch_state_e;
endpackage

/* File: rtl/pch_regs.svh */
// Register offsets, field positions, reset values and codes of the command handshake block.
`ifndef PCH_REGS_SVH
`define PCH_REGS_SVH
`define PCH_OFF_SET_REQ 8'h00
`define PCH_OFF_OP_REQ 8'h04
`define PCH_OFF_CMD 8'h08
`define PCH_OFF_BITS 8'h0C
`define PCH_OFF_VALUE 8'h10
`define PCH_OFF_RESP 8'h14
`define PCH_OFF_STATUS 8'h18
`define PCH_OFF_LIMIT 8'h1C
`define PCH_OFF_STORED 8'h20
`define PCH_OFF_EVENTS 8'h24
`define PCH_OFF_LAST 8'h28
`define PCH_REQ_STOP 16'h0000
`define PCH_REQ_SINGLE 16'h0001
`define PCH_REQ_MULTI 16'h0002
`define PCH_REQ_BSINGLE 16'h0003
`define PCH_REQ_BMULTI 16'h0004
`define PCH_CODE_HI 15
`define PCH_CODE_LO 10
`define PCH_UNIT_HI 9
`define PCH_UNIT_LO 4
`define PCH_ALLU_BIT 3
`define PCH_CH_HI 2
`define PCH_CH_LO 1
`define PCH_ALLC_BIT 0
`define PCH_OP_RUN 6'h0A
`define PCH_OP_STOP 6'h0B
`define PCH_OP_MANUAL 6'h0C
`define PCH_OP_AUTO 6'h0D
`define PCH_OP_TUNE40 6'h0E
`define PCH_OP_TUNE100 6'h0F
`define PCH_OP_TUNECAN 6'h10
`define PCH_OP_SWRESET 6'h06
`define PCH_LIMIT_RST 16'h270F
`define PCH_MAX_UNIT 6'h1F
`endif

/* File: rtl/pch_top.sv */
// Wishbone-reached command interpreter with set-value and command handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_top
   #(
   parameter int NUM_CH = 4
   )
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic [31:0] monitor_units_i,
   output pch_pkg::pch_issue_s issue_o,
   output logic [15:0] set_value_o,
   output logic set_apply_o
   );
   import pch_pkg::*;

   logic [15:0] set_req_ff;
   logic [15:0] op_req_ff;
   logic [15:0] cmd_ff;
   logic [15:0] bits_ff;
   logic [15:0] value_ff;
   logic [15:0] limit_ff;
   logic [15:0] stored_ff;
   logic [31:0] wb_dat_ff;
   logic wb_ack_ff;
   logic wb_err_ff;
   pch_issue_s issue_ff;
   logic [15:0] set_value_ff;
   logic set_apply_ff;
   logic [15:0] last_cmd_ff;
   logic [15:0] last_bits_ff;
   logic [15:0] pend_bits_ff;
   logic set_done_ff;
   logic op_done_ff;
   pch_state_e op_state_ff;
   logic [1:0] ch_ptr_ff;

   // Nets between the blocks, plus the event count, last word and flag registers.
   logic wb_req;
   logic wr_stb;
   logic [15:0] nxt_wdat;
   logic [15:0] set_active;
   logic set_start;
   logic [15:0] set_resp;
   logic [15:0] op_active;
   logic op_start;
   logic [15:0] op_resp;
   logic [15:0] bit_cmd;
   logic [15:0] dec_word;
   pch_issue_s dec_issue;
   logic [15:0] issue_cnt_ff;
   logic [15:0] last_word_ff;
   logic set_rej_ff;
   logic op_rej_ff;
   logic drop_ff;
   logic set_rej_evt;
   logic op_rej_evt;
   logic issue_now;
   logic drop_evt;
   logic evt_clr;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff && !wb_err_ff;
   // Writes land on the edge at which the master sees ack, never earlier.
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_ff;
   // Only the two low byte lanes carry a register word.
   assign nxt_wdat = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
      wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

   // Software-written request, command and value words.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         set_req_ff <= `PCH_REQ_STOP;
         op_req_ff <= `PCH_REQ_STOP;
         cmd_ff <= 16'h0000;
         bits_ff <= 16'h0000;
         value_ff <= 16'h0000;
         limit_ff <= `PCH_LIMIT_RST;
      end
      else if (wr_stb)
      begin
         case (wb_adr_i)
            `PCH_OFF_SET_REQ: set_req_ff <= nxt_wdat;
            `PCH_OFF_OP_REQ: op_req_ff <= nxt_wdat;
            `PCH_OFF_CMD: cmd_ff <= nxt_wdat;
            `PCH_OFF_BITS: bits_ff <= nxt_wdat;
            `PCH_OFF_VALUE: value_ff <= nxt_wdat;
            `PCH_OFF_LIMIT: limit_ff <= nxt_wdat;
            default: ;
         endcase
      end
   end

   // Bus answers one cycle after the request, error on unmapped offsets.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_ff <= 1'b0;
         wb_err_ff <= 1'b0;
         wb_dat_ff <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_ff <= 1'b0;
         wb_err_ff <= 1'b0;
         if (wb_req)
         begin
            wb_ack_ff <= 1'b1;
            case (wb_adr_i)
               `PCH_OFF_SET_REQ: wb_dat_ff <= {16'h0000, set_req_ff};
               `PCH_OFF_OP_REQ: wb_dat_ff <= {16'h0000, op_req_ff};
               `PCH_OFF_CMD: wb_dat_ff <= {16'h0000, cmd_ff};
               `PCH_OFF_BITS: wb_dat_ff <= {16'h0000, bits_ff};
               `PCH_OFF_VALUE: wb_dat_ff <= {16'h0000, value_ff};
               `PCH_OFF_RESP: wb_dat_ff <= {op_resp, set_resp};
               `PCH_OFF_STATUS: wb_dat_ff <= {op_active, set_active};
               `PCH_OFF_LIMIT: wb_dat_ff <= {16'h0000, limit_ff};
               `PCH_OFF_STORED: wb_dat_ff <= {16'h0000, stored_ff};
               `PCH_OFF_EVENTS: wb_dat_ff <= {13'h0000, drop_ff, op_rej_ff,
                  set_rej_ff, issue_cnt_ff};
               `PCH_OFF_LAST: wb_dat_ff <= {16'h0000, last_word_ff};
               default:
               begin
                  wb_ack_ff <= 1'b0;
                  wb_err_ff <= 1'b1;
                  wb_dat_ff <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // The apply logic never stalls, so the setting side always reports done.
   pch_handshake u_set_hs
      (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(set_req_ff),
      .done_i(set_done_ff),
      .active_o(set_active),
      .start_o(set_start),
      .resp_o(set_resp)
      );

   // The sequencer reports done only while it rests, so a stop request
   // waits for a running sequence to finish.
   pch_handshake u_op_hs
      (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(op_req_ff),
      .done_i(op_done_ff),
      .active_o(op_active),
      .start_o(op_start),
      .resp_o(op_resp)
      );

   // Setting change: a pass writes the value only when it does not exceed the limit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stored_ff <= 16'h0000;
         set_value_ff <= 16'h0000;
         set_apply_ff <= 1'b0;
         set_done_ff <= 1'b0;
      end
      else
      begin
         set_apply_ff <= 1'b0;
         set_done_ff <= 1'b1;
         if (set_start || (set_active == `PCH_REQ_MULTI &&
            value_ff != stored_ff) || set_active == `PCH_REQ_SINGLE &&
            set_start)
         begin
            if (value_ff <= limit_ff)
            begin
               stored_ff <= value_ff;
               set_value_ff <= value_ff;
               set_apply_ff <= 1'b1;
            end
         end
      end
   end

   // Bit-specified command for the channel currently being scanned.
   assign bit_cmd = {cmd_ff[15:3], ch_ptr_ff, 1'b0};
   assign dec_word = (op_active >= `PCH_REQ_BSINGLE) ? bit_cmd : cmd_ff;

   pch_decode u_dec
      (
      .word_i(dec_word),
      .monitor_units_i(monitor_units_i),
      .issue_o(dec_issue)
      );

   // Rejected code changes and dropped commands stay flagged until software
   // writes the event word; an event in the same cycle as the clear wins.
   assign set_rej_evt = wr_stb && wb_adr_i == `PCH_OFF_SET_REQ &&
      set_active != `PCH_REQ_STOP && nxt_wdat != `PCH_REQ_STOP &&
      nxt_wdat != set_active;
   assign op_rej_evt = wr_stb && wb_adr_i == `PCH_OFF_OP_REQ &&
      op_active != `PCH_REQ_STOP && nxt_wdat != `PCH_REQ_STOP &&
      nxt_wdat != op_active;
   assign issue_now = op_state_ff == PCH_BUSY &&
      (op_active <= `PCH_REQ_MULTI || pend_bits_ff[ch_ptr_ff]);
   assign drop_evt = issue_now && !dec_issue.valid;
   assign evt_clr = wr_stb && wb_adr_i == `PCH_OFF_EVENTS;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         set_rej_ff <= 1'b0;
         op_rej_ff <= 1'b0;
         drop_ff <= 1'b0;
      end
      else
      begin
         if (set_rej_evt)
            set_rej_ff <= 1'b1;
         else if (evt_clr)
            set_rej_ff <= 1'b0;
         if (op_rej_evt)
            op_rej_ff <= 1'b1;
         else if (evt_clr)
            op_rej_ff <= 1'b0;
         if (drop_evt)
            drop_ff <= 1'b1;
         else if (evt_clr)
            drop_ff <= 1'b0;
      end
   end

   // Count of commands handed out and the last word, channel field as issued.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         issue_cnt_ff <= 16'h0000;
         last_word_ff <= 16'h0000;
      end
      else if (issue_now && dec_issue.valid)
      begin
         issue_cnt_ff <= issue_cnt_ff + 16'h0001;
         last_word_ff <= dec_word;
      end
   end

   // Operation command sequencer.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         op_state_ff <= PCH_IDLE;
         issue_ff <= '0;
         last_cmd_ff <= 16'h0000;
         last_bits_ff <= 16'h0000;
         pend_bits_ff <= 16'h0000;
         ch_ptr_ff <= 2'd0;
         op_done_ff <= 1'b0;
      end
      else
      begin
         issue_ff.valid <= 1'b0;
         op_done_ff <= 1'b0;
         case (op_state_ff)
            PCH_IDLE:
            begin
               op_done_ff <= 1'b1;
               // A start always scans from channel zero.
               if (op_start)
               begin
                  last_cmd_ff <= cmd_ff;
                  last_bits_ff <= bits_ff;
                  pend_bits_ff <= bits_ff;
                  ch_ptr_ff <= 2'd0;
                  op_done_ff <= 1'b0;
                  op_state_ff <= PCH_BUSY;
               end
            end
            PCH_BUSY:
            begin
               if (op_active <= `PCH_REQ_MULTI)
               begin
                  issue_ff <= dec_issue;
                  op_state_ff <= PCH_DONE;
               end
               else
               begin
                  // Bit modes walk every channel once, issuing pending ones.
                  if (pend_bits_ff[ch_ptr_ff])
                     issue_ff <= dec_issue;
                  pend_bits_ff[ch_ptr_ff] <= 1'b0;
                  ch_ptr_ff <= ch_ptr_ff + 2'd1;
                  if (ch_ptr_ff == 2'(NUM_CH - 1))
                     op_state_ff <= PCH_DONE;
               end
            end
            PCH_DONE:
            begin
               op_done_ff <= 1'b1;
               // Multi modes stay here and rerun when their source word moves.
               if (op_active == `PCH_REQ_STOP)
                  op_state_ff <= PCH_IDLE;
               else if (op_active == `PCH_REQ_MULTI && cmd_ff != last_cmd_ff)
               begin
                  last_cmd_ff <= cmd_ff;
                  op_state_ff <= PCH_BUSY;
               end
               else if (op_active == `PCH_REQ_BMULTI &&
                  bits_ff != last_bits_ff)
               begin
                  pend_bits_ff <= bits_ff ^ last_bits_ff;
                  last_bits_ff <= bits_ff;
                  ch_ptr_ff <= 2'd0;
                  op_state_ff <= PCH_BUSY;
               end
            end
            default: op_state_ff <= PCH_IDLE;
         endcase
      end
   end

   // Outputs come straight from their flip-flops.
   assign wb_dat_o = wb_dat_ff;
   assign wb_ack_o = wb_ack_ff;
   assign wb_err_o = wb_err_ff;
   assign issue_o = issue_ff;
   assign set_value_o = set_value_ff;
   assign set_apply_o = set_apply_ff;
endmodule // pch_top
`default_nettype wire

/* File: test/pch_host.sv */
// Host controller model writing request words over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_host
   (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic err_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [31:0] dat_o
   );
   logic [31:0] rdat;
   logic rerr;
   initial
   begin
      cyc_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      dat_o = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      do
         @(posedge clk_i);
      while (!(ack_i || err_i));
      rdat = dat_i;
      rerr = err_i;
      cyc_o <= 1'b0;
      dat_o <= ~d;
   endtask
   // The data word goes out before its request code.
   task automatic set_value(input logic [15:0] v);
      xfer(1'b1, `PCH_OFF_VALUE, {16'h0000, v});
      xfer(1'b1, `PCH_OFF_SET_REQ, 32'h0000_0001);
   endtask
   task automatic command(input logic [15:0] w, input logic [15:0] c);
      xfer(1'b1, `PCH_OFF_CMD, {16'h0000, w});
      xfer(1'b1, `PCH_OFF_OP_REQ, {16'h0000, c});
   endtask
endmodule // pch_host
`default_nettype wire

/* File: test/pch_top_properties.sv */
// Port-level checks of the command handshake block.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_top_properties
   import pch_pkg::*;
   #(
   parameter int NUM_CH = 4
   )
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [31:0] monitor_units_i,
   input wire pch_issue_s issue_o,
   input wire logic [15:0] set_value_o,
   input wire logic set_apply_o
   );
   logic [15:0] cmd_ff, op_ff, lim_ff;
   logic [3:0] bits_ff, cnt_ff;
   logic wr;
   assign wr = wb_ack_o && wb_cyc_i && wb_we_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmd_ff <= 16'h0000;
         op_ff <= 16'h0000;
         lim_ff <= `PCH_LIMIT_RST;
         bits_ff <= 4'h0;
      end
      else if (wr)
      begin
         case (wb_adr_i)
            `PCH_OFF_CMD: cmd_ff <= wb_dat_i[15:0];
            `PCH_OFF_OP_REQ: op_ff <= wb_dat_i[15:0];
            `PCH_OFF_LIMIT: lim_ff <= wb_dat_i[15:0];
            `PCH_OFF_BITS: bits_ff <= wb_dat_i[3:0];
            default: ;
         endcase
      end
   end
   // Counts issues since the last operation request write.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (wr && wb_adr_i == `PCH_OFF_OP_REQ))
         cnt_ff <= 4'h0;
      else if (issue_o.valid)
         cnt_ff <= cnt_ff + 4'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   bus_answer_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
         |=> wb_ack_o ^ wb_err_o) else $error("bus not answered");
   code_match_a:
      assert property (issue_o.valid |-> issue_o.code == cmd_ff[15:10])
      else $error("issue code wrong");
   unit_one_a:
      assert property (issue_o.valid && !cmd_ff[3]
         |-> issue_o.unit_mask == 32'h0000_0001 << cmd_ff[9:4])
      else $error("unit mask wrong");
   all_units_a:
      assert property (issue_o.valid && cmd_ff[3] |-> issue_o.unit_mask ==
         ((issue_o.code == `PCH_OP_RUN || issue_o.code == `PCH_OP_SWRESET)
         ? ~monitor_units_i : 32'hFFFF_FFFF)) else $error("all units wrong");
   chan_sel_a:
      assert property (issue_o.valid && op_ff < 16'h0003 |-> issue_o.chan_mask
         == (cmd_ff[0] ? 4'hF : 4'h1 << cmd_ff[2:1]))
      else $error("channel mask wrong");
   bit_chan_a:
      assert property (issue_o.valid && op_ff > 16'h0002
         |-> $onehot(issue_o.chan_mask) && (issue_o.chan_mask & ~bits_ff) == 0)
      else $error("bit channel wrong");
   single_once_a:
      assert property (issue_o.valid && op_ff == `PCH_REQ_SINGLE
         |-> cnt_ff == 4'h0) else $error("single issued twice");
   range_keep_a:
      assert property (set_value_o != $past(set_value_o)
         |-> set_value_o <= lim_ff) else $error("out of range applied");
   apply_flag_a:
      assert property (set_value_o != $past(set_value_o) |-> set_apply_o)
      else $error("value changed without apply");
endmodule // pch_top_properties
bind pch_top pch_top_properties #(.NUM_CH(NUM_CH)) u_chk (.*);
`default_nettype wire

/* File: test/pch_top_tb.sv */
// Self-checking bench for the command handshake block.
`timescale 1ns/1ps
`default_nettype none
`include "pch_regs.svh"
module pch_top_tb;
   import pch_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, we, ack, err, apply;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   logic [31:0] mon = 32'h0000_0005;
   logic [15:0] value;
   pch_issue_s iss, last;
   int fails = 0;
   int tests_run = 0;
   int n_iss = 0;
   logic [15:0] cw [8] = '{16'h2809, 16'h2C09, 16'h3009, 16'h3409,
      16'h3809, 16'h3C09, 16'h4009, 16'h29F6};
   always #12.5 clk_i = ~clk_i;
   pch_host h (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat),
      .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat));
   pch_top #(.NUM_CH(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .monitor_units_i(mon), .issue_o(iss),
      .set_value_o(value), .set_apply_o(apply));
   always @(posedge clk_i)
      if (iss.valid === 1'b1)
      begin
         n_iss++;
         last = iss;
      end
   task automatic check(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
      int n;
      n = 0;
      do
      begin
         h.xfer(1'b0, a, 32'h0000_0000);
         n++;
      end
      while ((h.rdat & m) !== e && n < 40);
      check("read", h.rdat & m, e);
   endtask
   task automatic op(input logic [15:0] c);
      h.xfer(1'b1, `PCH_OFF_OP_REQ, {16'h0000, c});
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      tally_and_finish;
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      poll(`PCH_OFF_LIMIT, 32'hFFFF_FFFF, 32'h0000_270F);
      poll(`PCH_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
      h.xfer(1'b0, 8'h40, 32'h0000_0000);
      check("err", h.rerr, 1'b1);
      h.set_value(16'h03E8);
      poll(`PCH_OFF_RESP, 32'h0000_FFFF, 32'h0000_0001);
      check("value", value, 16'h03E8);
      h.xfer(1'b1, `PCH_OFF_SET_REQ, 32'h0000_0000);
      poll(`PCH_OFF_RESP, 32'h0000_FFFF, 32'h0000_0000);
      h.xfer(1'b1, `PCH_OFF_LIMIT, 32'h0000_0400);
      h.set_value(16'h0401);
      poll(`PCH_OFF_RESP, 32'h0000_FFFF, 32'h0000_0001);
      poll(`PCH_OFF_STORED, 32'h0000_FFFF, 32'h0000_03E8);
      check("kept", value, 16'h03E8);
      h.xfer(1'b1, `PCH_OFF_SET_REQ, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         n_iss = 0;
         h.command(cw[i], `PCH_REQ_SINGLE);
         poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0001_0000);
         check("count", n_iss, 1);
         check("code", last.code, cw[i][15:10]);
         check("unit", last.unit_mask, i == 0 ? ~mon :
            (i == 7 ? 32'h8000_0000 : 32'hFFFF_FFFF));
         check("chan", last.chan_mask, i == 7 ? 4'h8 : 4'hF);
         if (i == 7)
         begin
            op(`PCH_REQ_MULTI);
            poll(`PCH_OFF_STATUS, 32'hFFFF_0000, 32'h0001_0000);
            poll(`PCH_OFF_EVENTS, 32'h0007_0000, 32'h0002_0000);
            h.xfer(1'b1, `PCH_OFF_EVENTS, 32'h0000_0000);
         end
         op(`PCH_REQ_STOP);
         poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0000_0000);
      end
      h.command(16'h0009, `PCH_REQ_SINGLE);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0001_0000);
      poll(`PCH_OFF_EVENTS, 32'h0007_0000, 32'h0004_0000);
      op(`PCH_REQ_STOP);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0000_0000);
      h.xfer(1'b1, `PCH_OFF_EVENTS, 32'h0000_0000);
      n_iss = 0;
      h.command(16'h3409, `PCH_REQ_MULTI);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0002_0000);
      repeat (20) @(posedge clk_i);
      h.xfer(1'b1, `PCH_OFF_CMD, 32'h0000_3009);
      repeat (20) @(posedge clk_i);
      check("multi", n_iss, 2);
      op(`PCH_REQ_STOP);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0000_0000);
      h.xfer(1'b1, `PCH_OFF_BITS, 32'h0000_0005);
      n_iss = 0;
      h.command(16'h2809, `PCH_REQ_BSINGLE);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0003_0000);
      check("bits", n_iss, 2);
      op(`PCH_REQ_STOP);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0000_0000);
      n_iss = 0;
      op(`PCH_REQ_BMULTI);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0004_0000);
      repeat (20) @(posedge clk_i);
      check("first", n_iss, 2);
      h.xfer(1'b1, `PCH_OFF_BITS, 32'h0000_0007);
      repeat (20) @(posedge clk_i);
      check("changed", n_iss, 3);
      check("chg chan", last.chan_mask, 4'h2);
      op(`PCH_REQ_STOP);
      poll(`PCH_OFF_RESP, 32'hFFFF_0000, 32'h0000_0000);
      poll(`PCH_OFF_EVENTS, 32'h0007_FFFF, 32'h0000_000F);
      poll(`PCH_OFF_LAST, 32'h0000_FFFF, 32'h0000_280A);
      tally_and_finish;
   end
endmodule // pch_top_tb
`default_nettype wire
